// >>> core/i2ct_slave.sv
// Purpose: two-wire bus slave with address match, clock hold and bus time-out
// Assumes: lines have external pull-ups; firmware strobes are one cycle wide
// Notes: time-out counting lives on the low-speed oscillator clock
`timescale 1ns/1ps
`default_nettype none
module i2ct_slave (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_low_speed_oscillator_clk,
  input wire logic i_scl,
  output logic o_scl_o,
  output logic o_scl_oe_n,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe_n,
  input wire logic [2:0] i_serial_mode_field,
  input wire logic i_serial_unit_enable,
  input wire logic i_own_addr_wr,
  input wire logic [7:0] i_own_addr_wdata,
  output logic [7:0] o_own_address_register,
  input wire logic i_data_wr,
  input wire logic [7:0] i_data_wdata,
  input wire logic i_data_rd,
  output logic [7:0] o_serial_data_register,
  input wire logic i_status_wr,
  input wire i2ct_pkg::i2ct_stat_t i_status_wdata,
  output i2ct_pkg::i2ct_stat_t o_twowire_status_control,
  input wire logic i_timeout_wr,
  input wire i2ct_pkg::i2ct_toc_t i_timeout_wdata,
  output i2ct_pkg::i2ct_toc_t o_timeout_control_register,
  output logic o_serial_irq
);
  i2ct_pkg::i2ct_state_t st_q, st_d;
  i2ct_pkg::i2ct_stat_t stat_q, stat_d;
  i2ct_pkg::i2ct_toc_t toc_q, toc_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] dat_q, dat_d;
  logic [7:0] own_q, own_d;
  logic sda_oe_n_q, sda_oe_n_d;
  logic scl_oe_n_q, scl_oe_n_d;
  logic irq_q, irq_d;
  logic run_q, run_d;
  logic kick_q, kick_d;
  logic [i2ct_pkg::TO_FIELD_W-1:0] per_q, per_d;
  logic scl_p_q, sda_p_q;
  logic fire_p_q;
  logic [1:0] pin_s;
  logic fire_tgl, fire_s;
  logic scl_s, sda_s;
  logic scl_rise, scl_fall, start_evt, stop_evt, to_evt, active, release_hold;

  // pins come from outside the clock domain
  i2ct_sync2 #(.W(2)) u_pin_sync (
    .i_clk(i_sys_clk),
    .i_d({i_scl, i_sda}),
    .o_q(pin_s)
  );
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  i2ct_sync2 #(.W(1)) u_fire_sync (
    .i_clk(i_sys_clk),
    .i_d(fire_tgl),
    .o_q(fire_s)
  );

  i2ct_timeout u_timeout (
    .i_low_speed_oscillator_clk(i_low_speed_oscillator_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(run_q),
    .i_kick_tgl(kick_q),
    .i_period(per_q),
    .o_fire_tgl(fire_tgl)
  );

  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_evt = scl_s & scl_p_q & ~sda_s & sda_p_q;
  assign stop_evt = scl_s & scl_p_q & sda_s & ~sda_p_q;
  assign to_evt = fire_s ^ fire_p_q;
  assign active = (i_serial_mode_field == i2ct_pkg::MODE_TWOWIRE) && i_serial_unit_enable;
  // transmit select decides which firmware access frees the clock
  assign release_hold = stat_q.slave_transmit_select ? i_data_wr : i_data_rd;

  always_comb begin
    st_d = st_q;
    stat_d = stat_q;
    toc_d = toc_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    dat_d = dat_q;
    own_d = own_q;
    sda_oe_n_d = sda_oe_n_q;
    scl_oe_n_d = scl_oe_n_q;
    irq_d = 1'b0;
    run_d = run_q;
    kick_d = kick_q;
    per_d = per_q;

    if (i_own_addr_wr) begin
      own_d = i_own_addr_wdata;
    end
    if (i_data_wr) begin
      dat_d = i_data_wdata;
    end
    if (i_status_wr) begin
      stat_d.slave_transmit_select = i_status_wdata.slave_transmit_select;
      stat_d.ack_out_bit = i_status_wdata.ack_out_bit;
      stat_d.wake_enable = i_status_wdata.wake_enable;
    end
    if (i_timeout_wr) begin
      toc_d = i_timeout_wdata;
    end

    if (!active) begin
      // flags fall back to defaults; firmware-owned bits keep their value
      st_d = i2ct_pkg::ST_IDLE;
      stat_d.byte_done_flag = i2ct_pkg::STAT_POR.byte_done_flag;
      stat_d.address_match_flag = i2ct_pkg::STAT_POR.address_match_flag;
      stat_d.bus_busy_flag = i2ct_pkg::STAT_POR.bus_busy_flag;
      stat_d.master_read_request_flag = i2ct_pkg::STAT_POR.master_read_request_flag;
      stat_d.ack_in_flag = i2ct_pkg::STAT_POR.ack_in_flag;
      sda_oe_n_d = 1'b1;
      scl_oe_n_d = 1'b1;
      run_d = 1'b0;
    end else if (to_evt) begin
      st_d = i2ct_pkg::ST_IDLE;
      stat_d = i2ct_pkg::STAT_POR;
      toc_d.timeout_enable = 1'b0;
      toc_d.timeout_flag = 1'b1;
      irq_d = 1'b1;
      sda_oe_n_d = 1'b1;
      scl_oe_n_d = 1'b1;
      run_d = 1'b0;
    end else if (start_evt) begin
      stat_d.bus_busy_flag = 1'b1;
      stat_d.address_match_flag = 1'b0;
      stat_d.byte_done_flag = 1'b0;
      st_d = i2ct_pkg::ST_ADDR;
      cnt_d = '0;
      sda_oe_n_d = 1'b1;
      scl_oe_n_d = 1'b1;
      run_d = 1'b0;
    end else if (stop_evt) begin
      stat_d.bus_busy_flag = 1'b0;
      st_d = i2ct_pkg::ST_IDLE;
      sda_oe_n_d = 1'b1;
      scl_oe_n_d = 1'b1;
      run_d = 1'b0;
    end else begin
      if (scl_fall && run_q) begin
        kick_d = ~kick_q;
      end
      case (st_q)
        i2ct_pkg::ST_ADDR, i2ct_pkg::ST_RX: begin
          if (scl_rise && cnt_q <= i2ct_pkg::BIT_LAST_DATA) begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == i2ct_pkg::BIT_LAST_DATA) begin
              if (st_q == i2ct_pkg::ST_RX) begin
                dat_d = {sh_q[6:0], sda_s};
                stat_d.byte_done_flag = 1'b1;
                irq_d = 1'b1;
              end else if (sh_q[6:0] == own_q[7:1]) begin
                stat_d.address_match_flag = 1'b1;
                stat_d.master_read_request_flag = sda_s;
                irq_d = 1'b1;
                // period latched here and held for the whole run
                run_d = toc_q.timeout_enable;
                per_d = toc_q.timeout_period_field;
              end else begin
                st_d = i2ct_pkg::ST_WAIT_STOP;
              end
            end
          end else if (scl_fall && cnt_q == i2ct_pkg::BIT_ACK_SLOT) begin
            cnt_d = i2ct_pkg::BIT_ACK_END;
            if (st_q == i2ct_pkg::ST_ADDR) begin
              sda_oe_n_d = 1'b0;
            end else begin
              sda_oe_n_d = stat_q.ack_out_bit;
            end
          end else if (scl_fall && cnt_q == i2ct_pkg::BIT_ACK_END) begin
            sda_oe_n_d = 1'b1;
            scl_oe_n_d = 1'b0;
            st_d = i2ct_pkg::ST_HOLD;
          end
        end
        i2ct_pkg::ST_TX: begin
          if (scl_rise && cnt_q <= i2ct_pkg::BIT_LAST_DATA) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q != 4'h0 && cnt_q < i2ct_pkg::BIT_ACK_SLOT) begin
            sh_d = {sh_q[6:0], 1'b0};
            sda_oe_n_d = sh_q[6];
          end else if (scl_fall && cnt_q == i2ct_pkg::BIT_ACK_SLOT) begin
            sda_oe_n_d = 1'b1; // master owns the ack slot
            cnt_d = i2ct_pkg::BIT_ACK_END;
          end else if (scl_rise && cnt_q == i2ct_pkg::BIT_ACK_END) begin
            stat_d.ack_in_flag = sda_s;
            stat_d.byte_done_flag = 1'b1;
            irq_d = 1'b1;
          end else if (scl_fall && cnt_q == i2ct_pkg::BIT_ACK_END) begin
            if (stat_q.ack_in_flag) begin
              st_d = i2ct_pkg::ST_WAIT_STOP;
            end else begin
              scl_oe_n_d = 1'b0;
              st_d = i2ct_pkg::ST_HOLD;
            end
          end
        end
        i2ct_pkg::ST_HOLD: begin
          if (release_hold) begin
            scl_oe_n_d = 1'b1;
            stat_d.byte_done_flag = 1'b0;
            // match flag cleared so a later interrupt reads as byte done
            stat_d.address_match_flag = 1'b0;
            cnt_d = '0;
            if (stat_q.slave_transmit_select) begin
              st_d = i2ct_pkg::ST_TX;
              sh_d = i_data_wdata;
              sda_oe_n_d = i_data_wdata[7];
            end else begin
              st_d = i2ct_pkg::ST_RX;
            end
          end
        end
        i2ct_pkg::ST_WAIT_STOP: begin
          sda_oe_n_d = 1'b1;
        end
        default: begin
          st_d = i2ct_pkg::ST_IDLE;
        end
      endcase
    end
    // firmware disabling the time-out also stops a running count
    if (!toc_d.timeout_enable) begin
      run_d = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_q <= i2ct_pkg::ST_IDLE;
      stat_q <= i2ct_pkg::STAT_POR;
      toc_q <= i2ct_pkg::TOC_POR;
      cnt_q <= '0;
      sh_q <= '0;
      dat_q <= '0;
      own_q <= '0;
      sda_oe_n_q <= 1'b1;
      scl_oe_n_q <= 1'b1;
      irq_q <= 1'b0;
      run_q <= 1'b0;
      kick_q <= 1'b0;
      per_q <= '0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      fire_p_q <= 1'b0;
    end else begin
      st_q <= st_d;
      stat_q <= stat_d;
      toc_q <= toc_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      dat_q <= dat_d;
      own_q <= own_d;
      sda_oe_n_q <= sda_oe_n_d;
      scl_oe_n_q <= scl_oe_n_d;
      irq_q <= irq_d;
      run_q <= run_d;
      kick_q <= kick_d;
      per_q <= per_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      fire_p_q <= fire_s;
    end
  end

  // lines are only ever pulled low or released
  assign o_scl_o = 1'b0;
  assign o_sda_o = 1'b0;
  assign o_scl_oe_n = scl_oe_n_q;
  assign o_sda_oe_n = sda_oe_n_q;
  assign o_own_address_register = own_q;
  assign o_serial_data_register = dat_q;
  assign o_twowire_status_control = stat_q;
  assign o_timeout_control_register = toc_q;
  assign o_serial_irq = irq_q;
endmodule
`default_nettype wire

// >>> core/i2ct_pkg.sv
// Purpose: shared constants and carriers for the two-wire slave with bus time-out
// Assumes: firmware reaches every register through plain strobes and levels
// Notes: status/control layout follows the 8-bit status word, MSB = byte done
package i2ct_pkg;

  localparam logic [2:0] MODE_TWOWIRE = 3'h7;
  localparam int TO_FIELD_W = 6;
  localparam int TO_PRESC_W = 5;
  localparam int TO_CNT_W = TO_FIELD_W + TO_PRESC_W;
  localparam logic [TO_PRESC_W-1:0] TO_PRESC_LAST = 5'h1F;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_ACK_END = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_RX = 3'b010,
    ST_TX = 3'b011,
    ST_HOLD = 3'b100,
    ST_WAIT_STOP = 3'b101
  } i2ct_state_t;

  typedef struct packed {
    logic byte_done_flag;
    logic address_match_flag;
    logic bus_busy_flag;
    logic slave_transmit_select;
    logic ack_out_bit;
    logic master_read_request_flag;
    logic wake_enable;
    logic ack_in_flag;
  } i2ct_stat_t;

  typedef struct packed {
    logic timeout_enable;
    logic timeout_flag;
    logic [TO_FIELD_W-1:0] timeout_period_field;
  } i2ct_toc_t;

  localparam i2ct_stat_t STAT_POR = 8'h81;
  localparam i2ct_toc_t TOC_POR = 8'h00;

endpackage

// >>> core/i2ct_sync2.sv
// Purpose: two-flop level synchroniser
// Assumes: each bit is an independent level or toggle
// Notes: no reset, so it can also carry a reset into another domain
`timescale 1ns/1ps
`default_nettype none
module i2ct_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk) begin
    meta_q <= i_d;
    sync_q <= meta_q;
  end

  assign o_q = sync_q;
endmodule
`default_nettype wire

// >>> core/i2ct_timeout.sv
// Purpose: bus time-out counter on the low-speed oscillator
// Assumes: i_period is held stable while i_run is high
// Notes: fire is reported as a toggle back to the system side
`timescale 1ns/1ps
`default_nettype none
module i2ct_timeout (
  input wire logic i_low_speed_oscillator_clk,
  input wire logic i_sys_rst,
  input wire logic i_run,
  input wire logic i_kick_tgl,
  input wire logic [i2ct_pkg::TO_FIELD_W-1:0] i_period,
  output logic o_fire_tgl
);
  logic [2:0] s;
  logic kick_p_q, kick_p_d;
  logic fired_q, fired_d;
  logic fire_q, fire_d;
  logic [i2ct_pkg::TO_CNT_W-1:0] cnt_q, cnt_d;
  logic rst;

  // reset crosses as a level; release lags by two oscillator cycles
  i2ct_sync2 #(.W(3)) u_sync (
    .i_clk(i_low_speed_oscillator_clk),
    .i_d({i_sys_rst, i_run, i_kick_tgl}),
    .o_q(s)
  );
  assign rst = s[2];

  always_comb begin
    kick_p_d = s[0];
    fire_d = fire_q;
    fired_d = fired_q;
    cnt_d = cnt_q;
    if (!s[1]) begin
      cnt_d = '0;
      fired_d = 1'b0;
    end else if (s[0] != kick_p_q) begin
      cnt_d = '0;
    end else if (!fired_q) begin
      // period word only read while run is seen high, so it is stable here
      if (cnt_q == {i_period, i2ct_pkg::TO_PRESC_LAST}) begin
        fire_d = ~fire_q;
        fired_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_low_speed_oscillator_clk) begin
    if (rst) begin
      kick_p_q <= 1'b0;
      fire_q <= 1'b0;
      fired_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      kick_p_q <= kick_p_d;
      fire_q <= fire_d;
      fired_q <= fired_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_fire_tgl = fire_q;
endmodule
`default_nettype wire

// >>> verif/i2ct_checker.sv
// Purpose: port checks for the two-wire slave
// Assumes: pin sync plus edge detect takes at most six cycles
// Notes: bus events are taken from the wired lines
`timescale 1ns/1ps
`default_nettype none
module i2ct_checker (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_scl_o,
  input wire logic o_sda_o,
  input wire logic o_scl_oe_n,
  input wire logic i_data_wr,
  input wire logic i_data_rd,
  input wire logic [2:0] i_serial_mode_field,
  input wire logic i_serial_unit_enable,
  input wire logic i_timeout_wr,
  input wire i2ct_pkg::i2ct_toc_t i_timeout_wdata,
  input wire i2ct_pkg::i2ct_stat_t o_twowire_status_control,
  input wire i2ct_pkg::i2ct_toc_t o_timeout_control_register,
  input wire logic o_serial_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  wire [7:0] st = o_twowire_status_control;
  wire [7:0] tc = o_timeout_control_register;
  wire on = i_serial_unit_enable && i_serial_mode_field == 3'h7;
  logic irq_q;
  // irq registers in the same cycle as its flag; a delayed copy widens the window by a cycle
  always_ff @(posedge i_sys_clk) irq_q <= o_serial_irq;
  drive_low_a: assert property (!o_scl_o && !o_sda_o)
    else $error("line driven high");
  irq_pulse_a: assert property (o_serial_irq |=> !o_serial_irq)
    else $error("irq wider than one cycle");
  match_irq_a: assert property ($rose(st[6]) |-> ##[0:2] (o_serial_irq || irq_q))
    else $error("match without irq");
  done_irq_a: assert property (on && $rose(st[7]) |-> ##[0:2] (o_serial_irq || irq_q))
    else $error("byte done without irq");
  busy_set_a: assert property (on && i_scl && $fell(i_sda) |-> ##[1:6] st[5])
    else $error("start not seen");
  busy_clr_a: assert property (i_scl && $rose(i_sda) |-> ##[1:6] !st[5])
    else $error("stop not seen");
  release_a: assert property (!o_scl_oe_n && (st[4] ? i_data_wr : i_data_rd) |=> o_scl_oe_n)
    else $error("clock not released");
  tofire_a: assert property ($rose(tc[6]) && !$past(i_timeout_wr) |-> !tc[7] && st == 8'h81 && o_scl_oe_n)
    else $error("time-out result wrong");
  towrite_a: assert property (i_timeout_wr |=> tc == $past(i_timeout_wdata))
    else $error("time-out write lost");
endmodule
`default_nettype wire

// >>> verif/i2ct_master.sv
// Purpose: behavioural two-wire bus master
// Assumes: open-drain lines with pull-ups; output high means released
// Notes: clock stretch wait is bounded
`timescale 1ns/1ps
`default_nettype none
module i2ct_master #(
  parameter int H = 8
) (
  input wire logic i_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl = 1'b1,
  output logic o_sda = 1'b1
);
  task automatic w(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  // release only, never drive high; slave may stretch
  task automatic rise();
    o_scl = 1'b1;
    for (int n = 0; n < 400 && i_scl !== 1'b1; n++) begin
      w(1);
    end
    w(H);
  endtask
  // s=0 makes a start, s=1 a stop; sda moves while scl is high
  task automatic cond(input logic s);
    o_sda = !s;
    w(H);
    rise();
    o_sda = s;
    w(H);
    if (!s) begin
      o_scl = 1'b0;
      w(2);
    end
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      o_sda = d[i];
      w(H);
      rise();
      q[i] = i_sda;
      o_scl = 1'b0;
      w(2);
    end
    w(H);
  endtask
endmodule
`default_nettype wire

// >>> verif/i2ct_slave_tb.sv
// Purpose: self-checking bench for the two-wire slave
// Assumes: behavioural master on the far side
// Notes: firmware strobes are one cycle wide
`timescale 1ns/1ps
`default_nettype none
module i2ct_slave_tb;
  logic clk, lclk, rst, en, m_scl, m_sda, irq;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, own_wr, dat_wr, dat_rd, st_wr, tc_wr;
  logic [2:0] mode;
  logic [7:0] wd, own_q, dat_q;
  logic [8:0] r;
  i2ct_pkg::i2ct_stat_t st;
  i2ct_pkg::i2ct_toc_t tc;
  int miscompares, n_tests, irq_n, k;
  wire scl = m_scl & (scl_oe_n | scl_o);
  wire sda = m_sda & (sda_oe_n | sda_o);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #16 lclk = ~lclk;
  end
  i2ct_slave i_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_low_speed_oscillator_clk(lclk), .i_scl(scl), .o_scl_o(scl_o),
    .o_scl_oe_n(scl_oe_n), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .i_serial_mode_field(mode),
    .i_serial_unit_enable(en), .i_own_addr_wr(own_wr), .i_own_addr_wdata(wd), .o_own_address_register(own_q),
    .i_data_wr(dat_wr), .i_data_wdata(wd), .i_data_rd(dat_rd), .o_serial_data_register(dat_q),
    .i_status_wr(st_wr), .i_status_wdata(i2ct_pkg::i2ct_stat_t'(wd)), .o_twowire_status_control(st),
    .i_timeout_wr(tc_wr), .i_timeout_wdata(i2ct_pkg::i2ct_toc_t'(wd)), .o_timeout_control_register(tc),
    .o_serial_irq(irq));
  i2ct_master #(.H(8)) i_mst (.i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
  always @(posedge clk) if (irq === 1'b1) irq_n++;
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // k: 0 own address, 1 data write, 2 data read, 3 status, 4 time-out
  task automatic fw(input int k, input logic [7:0] d);
    wd = d;
    {own_wr, dat_wr, dat_rd, st_wr, tc_wr} = 5'h10 >> k;
    tk(1);
    {own_wr, dat_wr, dat_rd, st_wr, tc_wr} = 5'h00;
    tk(1);
  endtask
  task automatic t_write();
    fw(0, 8'hA5);
    chk(own_q, 8'hA5);
    fw(4, 8'h81);
    irq_n = 0;
    i_mst.cond(1'b0);
    i_mst.xbyte({8'hA4, 1'b1}, r);
    chk(r[0], 0);
    chk(st & 8'h64, 8'h60);
    chk(irq_n, 1);
    chk(scl, 0);
    fw(2, 8'h00);
    i_mst.xbyte({8'h5A, 1'b1}, r);
    chk(r[0], 0);
    chk(dat_q, 8'h5A);
    chk(st[7:6], 2'h2);
    chk(irq_n, 2);
    fw(3, 8'h08);
    fw(2, 8'h00);
    i_mst.xbyte({8'h81, 1'b1}, r);
    chk(r[0], 1);
    fw(2, 8'h00);
    i_mst.cond(1'b1);
    chk(st[5], 0);
    chk(tc, 8'h81);
    fw(3, 8'h00);
    fw(4, 8'h00);
    $display("write test done");
  endtask
  task automatic t_nomatch();
    for (int i = 0; i < 2; i++) begin
      i_mst.cond(1'b0);
      i_mst.xbyte({(i ? 8'h24 : 8'hA6), 1'b1}, r);
      chk(r[0], 1);
      chk(st[6], 0);
      i_mst.cond(1'b1);
    end
    $display("mismatch test done");
  endtask
  task automatic t_read();
    i_mst.cond(1'b0);
    i_mst.xbyte({8'hA5, 1'b1}, r);
    chk(st[2], 1);
    fw(3, 8'h10);
    fw(1, 8'hC3);
    i_mst.xbyte({8'hFF, 1'b0}, r);
    chk(r[8:1], 8'hC3);
    chk(st & 8'h81, 8'h80);
    chk(scl, 0);
    fw(1, 8'h3C);
    i_mst.xbyte({8'hFF, 1'b1}, r);
    chk(r[8:1], 8'h3C);
    chk({st[0], sda_oe_n, scl_oe_n}, 3'h7);
    i_mst.cond(1'b1);
    fw(3, 8'h00);
    $display("read test done");
  endtask
  task automatic t_off();
    for (int i = 0; i < 2; i++) begin
      {en, mode} = i ? 4'hE : 4'h7;
      tk(4);
      i_mst.cond(1'b0);
      i_mst.xbyte({8'hA4, 1'b1}, r);
      chk(r[0], 1);
      i_mst.cond(1'b1);
    end
    {en, mode} = 4'hF;
    tk(4);
    $display("disable test done");
  endtask
  task automatic t_timeout();
    fw(4, 8'h80);
    irq_n = 0;
    i_mst.cond(1'b0);
    i_mst.xbyte({8'hA4, 1'b1}, r);
    for (k = 0; k < 600 && tc[6] !== 1'b1; k++) begin
      tk(1);
    end
    tk(2);
    chk(k >= 180 && k <= 250, 1);
    chk(tc, 8'h40);
    chk(irq_n, 2);
    chk(st, 8'h81);
    chk({own_q, dat_q}, 16'hA53C);
    chk(scl_oe_n & sda_oe_n, 1);
    fw(4, 8'h00);
    chk(tc, 8'h00);
    i_mst.cond(1'b1);
    $display("time-out test done");
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    {rst, en, mode, wd} = 13'h1F00;
    {own_wr, dat_wr, dat_rd, st_wr, tc_wr} = 5'h00;
    // slow domain needs three of its own edges inside reset
    tk(24);
    rst = 1'b0;
    tk(3);
    chk(st, 8'h81);
    chk(tc, 8'h00);
    t_write();
    t_nomatch();
    t_read();
    t_off();
    t_timeout();
    print_verdict();
  end
endmodule
bind i2ct_slave i2ct_checker u_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl),
  .i_sda(i_sda), .o_scl_o(o_scl_o), .o_sda_o(o_sda_o), .o_scl_oe_n(o_scl_oe_n), .i_data_wr(i_data_wr),
  .i_data_rd(i_data_rd), .i_serial_mode_field(i_serial_mode_field), .i_serial_unit_enable(i_serial_unit_enable),
  .i_timeout_wr(i_timeout_wr), .i_timeout_wdata(i_timeout_wdata), .o_serial_irq(o_serial_irq),
  .o_twowire_status_control(o_twowire_status_control), .o_timeout_control_register(o_timeout_control_register));
`default_nettype wire
